// >>> hw/ieb_pkg.sv
// shared constants and types for the interrupt enable and priority bank
package ieb_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_SRC = 17;
   localparam int NUM_CFG = 8;
   localparam int NUM_REQ_SRC = 7;
   localparam int NUM_PRI_SRC = 10;
   localparam int PRIO_W = 3;
   localparam int REG_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SRC_W = 5;

   typedef logic [PRIO_W-1:0] ieb_prio_t;
   typedef logic [REG_W-1:0] ieb_word_t;

   // resolved request handed to the core
   typedef struct packed {
      logic valid;
      ieb_prio_t level;
      logic [SRC_W-1:0] source;
   } ieb_req_t;

   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [ADDR_W-1:0] OFS_EN2 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_EN3 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_EN4 = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_EN5 = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_PR0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PR1 = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PR2 = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PR3 = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_REQ = 8'h28;
   localparam int CFG_AW = 3;
   localparam int WORD_LSB = 2;

   // index of each config register in the bank
   localparam int CFG_EN2 = 0;
   localparam int CFG_EN3 = 1;
   localparam int CFG_EN4 = 2;
   localparam int CFG_EN5 = 3;
   localparam int CFG_PR0 = 4;
   localparam int CFG_PR1 = 5;
   localparam int CFG_PR2 = 6;
   localparam int CFG_PR3 = 7;

   // implemented bits, bits cut on the reduced variant, reset values
   localparam ieb_word_t CFG_IMPL [NUM_CFG] = '{16'h0020, 16'h0006, 16'h0106, 16'h0001,
                                                16'h7707, 16'h7700, 16'h7007, 16'h7077};
   localparam ieb_word_t CFG_CUT [NUM_CFG] = '{16'h0000, 16'h0006, 16'h0004, 16'h0000,
                                               16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam ieb_word_t CFG_RST [NUM_CFG] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                               16'h4404, 16'h4400, 16'h4004, 16'h4044};

   // ****************************************
   // field positions
   // ****************************************
   localparam int EN2_TMR3_GATE = 5;
   localparam int EN3_SER2_COLL = 2;
   localparam int EN3_SER2_EVT = 1;
   localparam int EN4_VDET = 8;
   localparam int EN4_UARTB_ERR = 2;
   localparam int EN4_UARTA_ERR = 1;
   localparam int EN5_LPWAKE = 0;
   localparam int PF_HI = 12;
   localparam int PF_MID = 8;
   localparam int PF_ADC = 4;
   localparam int PF_LO = 0;
   localparam ieb_prio_t PRIO_OFF = 3'h0;

   // ****************************************
   // source numbering
   // ****************************************
   localparam int SRC_TMR3_GATE = 0;
   localparam int SRC_SER2_COLL = 1;
   localparam int SRC_SER2_EVT = 2;
   localparam int SRC_VDET = 3;
   localparam int SRC_UARTB_ERR = 4;
   localparam int SRC_UARTA_ERR = 5;
   localparam int SRC_LPWAKE = 6;
   localparam int SRC_TMR1 = 7;
   localparam int SRC_CCP1 = 8;
   localparam int SRC_INT0 = 9;
   localparam int SRC_TMR2 = 10;
   localparam int SRC_CCP2 = 11;
   localparam int SRC_UARTA_RX = 12;
   localparam int SRC_TMR3 = 13;
   localparam int SRC_NVM = 14;
   localparam int SRC_ADC = 15;
   localparam int SRC_UARTA_TX = 16;
   localparam logic [NUM_SRC-1:0] SRC_CUT = 17'h00016;

endpackage

// >>> hw/ieb_resolve.sv
// picks the highest pending priority level among qualified sources
`timescale 1ns/1ps
`default_nettype none

module ieb_resolve
(
   // qualified requests
   input wire logic [ieb_pkg::NUM_SRC-1:0] req,
   input wire ieb_pkg::ieb_prio_t level [ieb_pkg::NUM_SRC],
   // winner
   output logic best_valid,
   output ieb_pkg::ieb_prio_t best_level,
   output logic [ieb_pkg::SRC_W-1:0] best_source
);

   logic chain_valid [ieb_pkg::NUM_SRC+1];
   ieb_pkg::ieb_prio_t chain_level [ieb_pkg::NUM_SRC+1];
   logic [ieb_pkg::SRC_W-1:0] chain_source [ieb_pkg::NUM_SRC+1];

   assign chain_valid[0] = 1'b0;
   assign chain_level[0] = ieb_pkg::PRIO_OFF;
   assign chain_source[0] = '0;

   // ****************************************
   // compare chain
   // ****************************************
   // strict greater-than: on equal levels the lower source number stays
   genvar g;
   generate
      for (g = 0; g < ieb_pkg::NUM_SRC; g++)
      begin : g_stage
         logic take;
         assign take = req[g] && (!chain_valid[g] || (level[g] > chain_level[g]));
         assign chain_valid[g+1] = chain_valid[g] | req[g];
         assign chain_level[g+1] = take ? level[g] : chain_level[g];
         assign chain_source[g+1] = take ? (ieb_pkg::SRC_W)'(g) : chain_source[g];
      end
   endgenerate

   assign best_valid = chain_valid[ieb_pkg::NUM_SRC];
   assign best_level = chain_level[ieb_pkg::NUM_SRC];
   assign best_source = chain_source[ieb_pkg::NUM_SRC];

endmodule

`default_nettype wire

// >>> hw/ieb_bank.sv
// interrupt enable and priority register bank with apb access
//
// Overview of operation
// - set enable passes request, clear blocks it
// - three-bit priority, code 111 is level 7
// - code 001 is level 1, linear between
// - priority 000 removes the source from the core request, not from irq
// - unimplemented bits read zero, ignore writes
// - reset: enables zero, priorities load 100
// - enable reg 2: timer3 gate at bit 5
// - enable reg 3: collision bit 2, event 1
// - enable reg 4: bits 8, 2, 1
// - enable reg 5: wake-up at bit 0
// - priority reg 0: fields 14-12, 10-8, 2-0
// - priority reg 1: fields 14-12, 10-8
// - priority reg 2: fields 14-12, 2-0
// - priority reg 3: fields 14-12, 6-4, 2-0
// - reduced variant drops second port bits
// - per-source flag set once request occurs
`timescale 1ns/1ps
`default_nettype none

module ieb_bank
#(
   parameter logic FULL_VARIANT = 1'b1
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ieb_pkg::ADDR_W-1:0] paddr,
   input wire logic [ieb_pkg::DATA_W-1:0] pwdata,
   output logic [ieb_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // peripheral sources, same clock
   input wire logic [ieb_pkg::NUM_SRC-1:0] src_event,
   input wire logic [ieb_pkg::NUM_PRI_SRC-1:0] ext_enable,
   input wire ieb_pkg::ieb_prio_t ext_priority [ieb_pkg::NUM_REQ_SRC],
   // to the core
   output logic irq,
   output ieb_pkg::ieb_req_t cpu_req
);

   // ****************************************
   // apb phases and decode
   // ****************************************
   logic setup_phase;
   logic access_phase;
   logic wr_access;
   logic rd_access;
   logic addr_is_cfg;
   logic [ieb_pkg::CFG_AW-1:0] cfg_sel;
   logic addr_known;
   logic sel_flag;
   logic sel_mask;
   logic sel_req;
   logic cfg_wr;

   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign wr_access = access_phase & pwrite;
   assign rd_access = access_phase & ~pwrite;
   // every register answers in its first access cycle
   assign pready = access_phase;
   assign addr_is_cfg = (paddr <= ieb_pkg::OFS_PR3) && (paddr[ieb_pkg::WORD_LSB-1:0] == 2'h0);
   assign cfg_sel = paddr[ieb_pkg::WORD_LSB +: ieb_pkg::CFG_AW];
   assign cfg_wr = wr_access & addr_is_cfg;
   assign sel_flag = (paddr == ieb_pkg::OFS_FLAG);
   assign sel_mask = (paddr == ieb_pkg::OFS_MASK);
   assign sel_req = (paddr == ieb_pkg::OFS_REQ);
   // writes to the flag and request views are dropped without an error
   assign addr_known = addr_is_cfg
                       || sel_flag
                       || sel_mask
                       || sel_req;

   // ****************************************
   // configuration bank
   // ****************************************
   ieb_pkg::ieb_word_t cfg_reg [ieb_pkg::NUM_CFG];
   ieb_pkg::ieb_word_t cfg_next [ieb_pkg::NUM_CFG];
   ieb_pkg::ieb_word_t cfg_keep [ieb_pkg::NUM_CFG];

   genvar r;
   generate
      for (r = 0; r < ieb_pkg::NUM_CFG; r++)
      begin : g_cfg
         logic wr_hit;

         // bits missing on the reduced part behave as unimplemented
         assign cfg_keep[r] = FULL_VARIANT ? ieb_pkg::CFG_IMPL[r]
                                           : (ieb_pkg::CFG_IMPL[r] & ~ieb_pkg::CFG_CUT[r]);
         assign wr_hit = cfg_wr && (cfg_sel == (ieb_pkg::CFG_AW)'(r));

         always_comb
         begin
            cfg_next[r] = cfg_reg[r];
            if (wr_hit)
            begin
               cfg_next[r] = pwdata[ieb_pkg::REG_W-1:0] & cfg_keep[r];
            end
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               cfg_reg[r] <= ieb_pkg::CFG_RST[r];
            end
            else
            begin
               cfg_reg[r] <= cfg_next[r];
            end
         end
      end
   endgenerate

   // ****************************************
   // per-source enable and priority
   // ****************************************
   logic [ieb_pkg::NUM_SRC-1:0] src_enable;
   ieb_pkg::ieb_prio_t src_prio [ieb_pkg::NUM_SRC];

   assign src_enable[ieb_pkg::SRC_TMR3_GATE] = cfg_reg[ieb_pkg::CFG_EN2][ieb_pkg::EN2_TMR3_GATE];
   assign src_enable[ieb_pkg::SRC_SER2_COLL] = cfg_reg[ieb_pkg::CFG_EN3][ieb_pkg::EN3_SER2_COLL];
   assign src_enable[ieb_pkg::SRC_SER2_EVT] = cfg_reg[ieb_pkg::CFG_EN3][ieb_pkg::EN3_SER2_EVT];
   assign src_enable[ieb_pkg::SRC_VDET] = cfg_reg[ieb_pkg::CFG_EN4][ieb_pkg::EN4_VDET];
   assign src_enable[ieb_pkg::SRC_UARTB_ERR] = cfg_reg[ieb_pkg::CFG_EN4][ieb_pkg::EN4_UARTB_ERR];
   assign src_enable[ieb_pkg::SRC_UARTA_ERR] = cfg_reg[ieb_pkg::CFG_EN4][ieb_pkg::EN4_UARTA_ERR];
   assign src_enable[ieb_pkg::SRC_LPWAKE] = cfg_reg[ieb_pkg::CFG_EN5][ieb_pkg::EN5_LPWAKE];

   assign src_prio[ieb_pkg::SRC_TMR1] = cfg_reg[ieb_pkg::CFG_PR0][ieb_pkg::PF_HI +: ieb_pkg::PRIO_W];
   assign src_prio[ieb_pkg::SRC_CCP1] = cfg_reg[ieb_pkg::CFG_PR0][ieb_pkg::PF_MID +: ieb_pkg::PRIO_W];
   assign src_prio[ieb_pkg::SRC_INT0] = cfg_reg[ieb_pkg::CFG_PR0][ieb_pkg::PF_LO +: ieb_pkg::PRIO_W];
   assign src_prio[ieb_pkg::SRC_TMR2] = cfg_reg[ieb_pkg::CFG_PR1][ieb_pkg::PF_HI +: ieb_pkg::PRIO_W];
   assign src_prio[ieb_pkg::SRC_CCP2] = cfg_reg[ieb_pkg::CFG_PR1][ieb_pkg::PF_MID +: ieb_pkg::PRIO_W];
   assign src_prio[ieb_pkg::SRC_UARTA_RX] = cfg_reg[ieb_pkg::CFG_PR2][ieb_pkg::PF_HI +: ieb_pkg::PRIO_W];
   assign src_prio[ieb_pkg::SRC_TMR3] = cfg_reg[ieb_pkg::CFG_PR2][ieb_pkg::PF_LO +: ieb_pkg::PRIO_W];
   assign src_prio[ieb_pkg::SRC_NVM] = cfg_reg[ieb_pkg::CFG_PR3][ieb_pkg::PF_HI +: ieb_pkg::PRIO_W];
   assign src_prio[ieb_pkg::SRC_ADC] = cfg_reg[ieb_pkg::CFG_PR3][ieb_pkg::PF_ADC +: ieb_pkg::PRIO_W];
   assign src_prio[ieb_pkg::SRC_UARTA_TX] = cfg_reg[ieb_pkg::CFG_PR3][ieb_pkg::PF_LO +: ieb_pkg::PRIO_W];

   // the partner half of each source lives in registers outside this bank
   genvar s;
   generate
      for (s = 0; s < ieb_pkg::NUM_REQ_SRC; s++)
      begin : g_ext_prio
         assign src_prio[s] = ext_priority[s];
      end
      for (s = 0; s < ieb_pkg::NUM_PRI_SRC; s++)
      begin : g_ext_en
         assign src_enable[ieb_pkg::NUM_REQ_SRC + s] = ext_enable[s];
      end
   endgenerate

   // ****************************************
   // flags and interrupt mask
   // ****************************************
   logic [ieb_pkg::NUM_SRC-1:0] src_live;
   logic [ieb_pkg::NUM_SRC-1:0] flag_reg;
   logic [ieb_pkg::NUM_SRC-1:0] flag_next;
   logic [ieb_pkg::NUM_SRC-1:0] mask_reg;
   logic [ieb_pkg::NUM_SRC-1:0] mask_next;
   logic [ieb_pkg::NUM_SRC-1:0] flag_seen_reg;
   logic [ieb_pkg::NUM_SRC-1:0] flag_seen_next;
   logic flag_rd_reg;
   logic flag_rd_next;

   // flags of sources absent on the reduced part can never set
   assign src_live = FULL_VARIANT ? '1 : ~ieb_pkg::SRC_CUT;

   // a read clears only what the read returned, so a flag raised after
   // the setup cycle survives; a new event always beats the clear
   always_comb
   begin
      flag_seen_next = flag_seen_reg;
      flag_rd_next = flag_rd_reg;
      flag_next = flag_reg;
      mask_next = mask_reg;
      if (setup_phase)
      begin
         flag_rd_next = ~pwrite && sel_flag;
         flag_seen_next = flag_reg;
      end
      if (rd_access && flag_rd_reg)
      begin
         flag_next = flag_next & ~flag_seen_reg;
      end
      flag_next = (flag_next | src_event) & src_live;
      if (wr_access && sel_mask)
      begin
         mask_next = pwdata[ieb_pkg::NUM_SRC-1:0] & src_live;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_reg <= '0;
         mask_reg <= '0;
         flag_seen_reg <= '0;
         flag_rd_reg <= 1'b0;
      end
      else
      begin
         flag_reg <= flag_next;
         mask_reg <= mask_next;
         flag_seen_reg <= flag_seen_next;
         flag_rd_reg <= flag_rd_next;
      end
   end

   // ****************************************
   // qualification and resolution
   // ****************************************
   logic [ieb_pkg::NUM_SRC-1:0] src_qual;
   logic best_valid;
   ieb_pkg::ieb_prio_t best_level;
   logic [ieb_pkg::SRC_W-1:0] best_source;

   generate
      for (s = 0; s < ieb_pkg::NUM_SRC; s++)
      begin : g_qual
         // level equals the code: 001 lowest through 111 highest
         assign src_qual[s] = flag_reg[s]
                              & src_enable[s]
                              & (src_prio[s] != ieb_pkg::PRIO_OFF);
      end
   endgenerate

   ieb_resolve u_resolve
   (
      .req(src_qual),
      .level(src_prio),
      .best_valid(best_valid),
      .best_level(best_level),
      .best_source(best_source)
   );

   // ****************************************
   // outputs to the core
   // ****************************************
   // registered so the core sees a clean level and source, at one cycle of latency
   ieb_pkg::ieb_req_t req_reg;
   ieb_pkg::ieb_req_t req_next;
   logic irq_reg;
   logic irq_next;

   always_comb
   begin
      req_next.valid = best_valid;
      req_next.level = best_valid ? best_level : ieb_pkg::PRIO_OFF;
      req_next.source = best_valid ? best_source : '0;
      // irq follows the mask alone; enable and priority shape only the core request
      irq_next = |(flag_reg & mask_reg);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         req_reg <= req_next;
         irq_reg <= irq_next;
      end
   end

   assign cpu_req = req_reg;
   assign irq = irq_reg;

   // ****************************************
   // read path
   // ****************************************
   // read data is caught in the setup cycle so prdata comes from flops
   logic [ieb_pkg::DATA_W-1:0] rdata_reg;
   logic [ieb_pkg::DATA_W-1:0] rdata_next;
   logic err_reg;
   logic err_next;

   always_comb
   begin
      rdata_next = rdata_reg;
      err_next = err_reg;
      if (setup_phase)
      begin
         err_next = ~addr_known;
         rdata_next = '0;
         if (!pwrite)
         begin
            if (addr_is_cfg)
            begin
               rdata_next[ieb_pkg::REG_W-1:0] = cfg_reg[cfg_sel] & cfg_keep[cfg_sel];
            end
            else if (sel_flag)
            begin
               rdata_next[ieb_pkg::NUM_SRC-1:0] = flag_reg;
            end
            else if (sel_mask)
            begin
               rdata_next[ieb_pkg::NUM_SRC-1:0] = mask_reg;
            end
            else if (sel_req)
            begin
               rdata_next[$bits(ieb_pkg::ieb_req_t)-1:0] = req_reg;
            end
            else
            begin
               rdata_next = '0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_reg <= '0;
         err_reg <= 1'b0;
      end
      else
      begin
         rdata_reg <= rdata_next;
         err_reg <= err_next;
      end
   end

   assign prdata = rdata_reg;
   assign pslverr = access_phase & err_reg;

endmodule

`default_nettype wire

// >>> sim/ieb_checker.sv
// concurrent checks on the ports of the enable and priority bank
`timescale 1ns/1ps
`default_nettype none

module ieb_checker
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ieb_pkg::ADDR_W-1:0] paddr,
   input wire logic [ieb_pkg::DATA_W-1:0] prdata,
   input wire logic pslverr,
   // sources and core side
   input wire logic [ieb_pkg::NUM_SRC-1:0] src_event,
   input wire logic irq,
   input wire ieb_pkg::ieb_req_t cpu_req
);
   // ****************************************
   // helpers
   // ****************************************
   logic [2:0] idle_reg;
   logic [2:0] idle_next;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // cycles since software last touched flag or mask, saturating
   always_comb
   begin
      idle_next = idle_reg;
      if (psel && penable && (paddr == 8'h20 || paddr == 8'h24))
         idle_next = 3'h0;
      else if (idle_reg != 3'h7)
         idle_next = idle_reg + 3'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         idle_reg <= 3'h0;
      else
         idle_reg <= idle_next;
   end

   sequence rd_at(logic [7:0] a);
      psel && penable && !pwrite && paddr == a;
   endsequence

   // no bus traffic and no source activity
   sequence calm;
      !psel && src_event == '0;
   endsequence

   // ****************************************
   // assertions
   // ****************************************
   AST_EN2_BITS: assert property (rd_at(8'h00) |-> (prdata & ~32'h20) == 32'h0)
      else $error("enable 2 stray bit");
   AST_EN4_BITS: assert property (rd_at(8'h08) |-> (prdata & ~32'h106) == 32'h0)
      else $error("enable 4 stray bit");
   AST_EN5_BITS: assert property (rd_at(8'h0c) |-> (prdata & ~32'h1) == 32'h0)
      else $error("enable 5 stray bit");
   AST_PR0_BITS: assert property (rd_at(8'h10) |-> (prdata & ~32'h7707) == 32'h0)
      else $error("priority 0 stray bit");
   AST_PR3_BITS: assert property (rd_at(8'h1c) |-> (prdata & ~32'h7077) == 32'h0)
      else $error("priority 3 stray bit");
   AST_HIGH_ZERO: assert property (psel && penable && !pwrite |-> prdata[31:17] == 15'h0)
      else $error("upper read bits set");
   AST_SLVERR: assert property (psel && penable |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h28))
      else $error("error response wrong");
   AST_LEVEL_LIVE: assert property (cpu_req.valid |-> cpu_req.level != 3'h0)
      else $error("request at level zero");
   AST_CALM_HOLD: assert property (calm [*3] |-> $stable(cpu_req) && $stable(irq))
      else $error("output moved without cause");
   AST_IRQ_DROP: assert property ($fell(irq) |-> idle_reg < 3'h4)
      else $error("irq fell without clear");
endmodule

bind ieb_bank ieb_checker u_chk
(
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .prdata(prdata),
   .pslverr(pslverr),
   .src_event(src_event),
   .irq(irq),
   .cpu_req(cpu_req)
);

`default_nettype wire

// >>> sim/ieb_src_model.sv
// peripheral side model: request strobes and the outside enable and priority halves
`timescale 1ns/1ps
`default_nettype none

module ieb_src_model
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench commands
   input wire logic [ieb_pkg::NUM_SRC-1:0] fire,
   input wire logic [ieb_pkg::NUM_PRI_SRC-1:0] en_cmd,
   input wire logic [20:0] pri_cmd,
   // toward the bank
   output logic [ieb_pkg::NUM_SRC-1:0] src_event,
   output logic [ieb_pkg::NUM_PRI_SRC-1:0] ext_enable,
   output ieb_pkg::ieb_prio_t ext_priority [ieb_pkg::NUM_REQ_SRC]
);
   logic [ieb_pkg::NUM_SRC-1:0] fire_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fire_reg <= '0;
      else
         fire_reg <= fire;
   end

   // one-cycle strobe per new command, as a peripheral raises its request
   always_comb
   begin
      src_event = fire & ~fire_reg;
      ext_enable = en_cmd;
      for (int k = 0; k < ieb_pkg::NUM_REQ_SRC; k++)
         ext_priority[k] = pri_cmd[3*k +: 3];
   end
endmodule

`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the enable and priority bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
   // ****************************************
   // signals and tables
   // ****************************************
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] prdata_red;
   logic pready;
   logic pslverr;
   logic [16:0] fire;
   logic [9:0] en_cmd;
   logic [20:0] pri_cmd;
   logic [16:0] src_event;
   logic [9:0] ext_enable;
   ieb_pkg::ieb_prio_t ext_priority [7];
   logic irq;
   ieb_pkg::ieb_req_t cpu_req;
   logic [31:0] rd;
   logic [31:0] rd_red;
   logic err;
   int err_count;
   int check_count;
   localparam logic [15:0] IMPL [8] = '{16'h20, 16'h6, 16'h106, 16'h1, 16'h7707, 16'h7700, 16'h7007, 16'h7077};
   localparam logic [15:0] CUT [8] = '{16'h0, 16'h6, 16'h4, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
   localparam logic [15:0] RSTV [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h4404, 16'h4400, 16'h4004, 16'h4044};
   localparam logic [7:0] PR_OFS [10] = '{8'h10, 8'h10, 8'h10, 8'h14, 8'h14, 8'h18, 8'h18, 8'h1c, 8'h1c, 8'h1c};
   localparam int PR_SH [10] = '{12, 8, 0, 12, 8, 12, 0, 12, 4, 0};
   localparam logic [7:0] EN_OFS [7] = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h0c};
   localparam int EN_BIT [7] = '{5, 2, 1, 8, 2, 1, 0};

   ieb_bank #(.FULL_VARIANT(1'b1)) u_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_event(src_event), .ext_enable(ext_enable), .ext_priority(ext_priority),
      .irq(irq), .cpu_req(cpu_req)
   );

   // reduced part on the same bus, only its read data is watched
   ieb_bank #(.FULL_VARIANT(1'b0)) u_red
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata_red), .pready(), .pslverr(),
      .src_event(src_event), .ext_enable(ext_enable), .ext_priority(ext_priority),
      .irq(), .cpu_req()
   );

   ieb_src_model u_src
   (
      .pclk(pclk), .presetn(presetn), .fire(fire), .en_cmd(en_cmd), .pri_cmd(pri_cmd),
      .src_event(src_event), .ext_enable(ext_enable), .ext_priority(ext_priority)
   );

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata;
      rd_red = prdata_red;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic pulse(input logic [16:0] m);
      fire <= m;
      repeat (2) @(posedge pclk);
      fire <= '0;
      repeat (2) @(posedge pclk);
   endtask

   // level and source only mean something while valid
   task automatic req_is(input logic [8:0] want);
      repeat (2) @(posedge pclk);
      if (want[8])
         check({23'h0, cpu_req}, {23'h0, want});
      else
         check({31'h0, cpu_req.valid}, 32'h0);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ****************************************
   // clock, watchdog, tests
   // ****************************************
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   initial
   begin
      repeat (20000) @(posedge pclk);
      err_count++;
      tally_and_finish();
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      fire = '0;
      en_cmd = '0;
      pri_cmd = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b0, 8'(4 * i), 32'h0);
         check(rd, {16'h0, RSTV[i]});
         bus(1'b1, 8'(4 * i), 32'hffffffff);
         bus(1'b0, 8'(4 * i), 32'h0);
         check(rd, {16'h0, IMPL[i]});
         check(rd_red, {16'h0, IMPL[i] & ~CUT[i]});
         bus(1'b1, 8'(4 * i), 32'h0);
      end
      bus(1'b1, 8'h2c, 32'hffffffff);
      check({31'h0, err}, 32'h1);
      bus(1'b0, 8'h1e, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      // every outside-enabled source through its own priority field
      pulse(17'h1ff80);
      for (int j = 0; j < 10; j++)
      begin
         en_cmd <= 10'(1 << j);
         bus(1'b1, PR_OFS[j], 32'(j % 7 + 1) << PR_SH[j]);
         req_is({1'b1, 3'(j % 7 + 1), 5'(j + 7)});
         en_cmd <= '0;
         bus(1'b1, PR_OFS[j], 32'h0);
         req_is(9'h0);
      end
      en_cmd <= 10'h5;
      bus(1'b1, 8'h10, 32'h3005);
      req_is({1'b1, 3'd5, 5'd9});
      bus(1'b0, 8'h28, 32'h0);
      check(rd, 32'h1a9);
      bus(1'b1, 8'h10, 32'h5005);
      req_is({1'b1, 3'd5, 5'd7});
      en_cmd <= '0;
      bus(1'b1, 8'h10, 32'h0);
      // bank-enabled sources, each at its own level
      pri_cmd <= {3'd7, 3'd6, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1};
      pulse(17'h7f);
      req_is(9'h0);
      for (int k = 0; k < 7; k++)
      begin
         bus(1'b1, EN_OFS[k], 32'h1 << EN_BIT[k]);
         req_is({1'b1, 3'(k + 1), 5'(k)});
         if (k == 6)
            pri_cmd[20:18] <= 3'h0;
         bus(1'b1, EN_OFS[k], 32'h1 << EN_BIT[k]);
         req_is(k == 6 ? 9'h0 : {1'b1, 3'(k + 1), 5'(k)});
         bus(1'b1, EN_OFS[k], 32'h0);
      end
      bus(1'b1, 8'h20, 32'h0);
      check({31'h0, err}, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      check(rd, 32'h1ffff);
      check(rd_red, 32'h1ffe9);
      bus(1'b0, 8'h20, 32'h0);
      check(rd, 32'h0);
      // interrupt: masked event stays quiet, unmasked one raises, read clears
      bus(1'b1, 8'h24, 32'h8000);
      pulse(17'h4000);
      check({31'h0, irq}, 32'h0);
      pulse(17'h8000);
      check({31'h0, irq}, 32'h1);
      bus(1'b0, 8'h24, 32'h0);
      check(rd, 32'h8000);
      bus(1'b0, 8'h20, 32'h0);
      check(rd, 32'hc000);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      tally_and_finish();
   end
endmodule

`default_nettype wire
